/* File: bench/frame_decoder_chk.sv */
/* Port assertions for the frame decoder.
   Assumes it is bound to every decoder instance. */
`timescale 1ns/1ps
module frame_decoder_chk #(parameter CODE_W = 12) (
    input wire core_clk,
    input wire reset_n,
    input wire twos_comp_sel,
    input wire frame_valid,
    input wire frame_error,
    input wire frame_read,
    input wire [2:0] target_sel,
    input wire [2:0] channel_addr,
    input wire [15:0] frame_data,
    input wire [3:0] channel_we,
    input wire range_we,
    input wire reg_re,
    input wire [CODE_W-1:0] code_a,
    input wire [11:0] level_a,
    input wire [11:0] range_a_to_d
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence dac_wr;
        frame_valid && !frame_read && target_sel == 3'h0;
    endsequence
    a_one_outcome: assert property (!(frame_valid && frame_error))
        else $error("valid with error");
    a_valid_pulse: assert property (frame_valid |=> !frame_valid)
        else $error("long valid");
    a_error_pulse: assert property (frame_error |=> !frame_error)
        else $error("long error");
    a_all_channels: assert property (dac_wr ##0 channel_addr == 3'h4 |-> channel_we == 4'hf)
        else $error("all channels");
    a_range_route: assert property (range_we |-> frame_valid && !frame_read && target_sel == 3'h1)
        else $error("range route");
    a_read_route: assert property (reg_re |-> frame_valid && frame_read && channel_we == 4'h0)
        else $error("read route");
    a_code_take: assert property (channel_we[0] |=> code_a == frame_data[15:16-CODE_W])
        else $error("code a");
    // Bipolar twos complement flips the sign bit, everything else passes through
    a_level_map: assert property (channel_we[0] |=> level_a ==
        (range_a_to_d[2:0] > 3'h2 && twos_comp_sel ? code_a ^ 12'h800 : code_a))
        else $error("level a");
endmodule
bind quad_dac_serial_frame_decoder frame_decoder_chk #(.CODE_W(CODE_W)) i_chk (.*);

/* File: bench/quad_dac_serial_frame_decoder_test.sv */
/* Bench for the frame decoder against a reference model.
   Assumes the host model drives the serial lines. */
`timescale 1ns/1ps
module quad_dac_serial_frame_decoder_test;
    logic core_clk = 0, reset_n = 0, twos_comp_sel = 0;
    logic serial_clk, frame_sel_n, serial_data_in, frame_valid, frame_error, frame_read;
    logic range_we, power_we, ctrl_we, reg_re;
    logic [2:0] target_sel, channel_addr;
    logic [3:0] channel_we, channel_re, m;
    logic [15:0] frame_data;
    logic [11:0] code_a, code_b, code_c, code_d, level_a, level_b, level_c, level_d, range_a_to_d;
    logic [47:0] e, l;
    logic [23:0] w;
    int codes[4], rng[4], errors, samples_checked, cyc, k;
    quad_dac_serial_frame_decoder i_dut (.*);
    serial_host_model i_host (.*);
    always #2 core_clk = ~core_clk;
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            wrap_up;
        end
    end
    task automatic frame(input int nbits);
        m = w[18:16] < 4 ? 4'h1 << w[18:16] : {4{w[18:16] == 3'h4}};
        i_host.send(w, nbits);
        k = 0;
        while (frame_valid !== 1'b1 && frame_error !== 1'b1 && k < 30) begin
            @(negedge core_clk);
            k++;
        end
        check({frame_valid, frame_error}, {nbits == 24, nbits != 24});
        if (nbits == 24) begin
            check({frame_read, target_sel, channel_addr, frame_data}, {w[23], w[21:0]});
            check({channel_we, channel_re, range_we, power_we, ctrl_we, reg_re},
                {w[23] || w[21:19] ? 4'h0 : m, w[23] && !w[21:19] ? m : 4'h0,
                !w[23] && w[21:19] == 1, !w[23] && w[21:19] == 2,
                !w[23] && w[21:19] == 3, w[23]});
            for (int c = 0; c < 4; c++) begin
                if (!w[23] && m[c] && w[21:19] == 0) codes[c] = w[15:4];
                if (!w[23] && m[c] && w[21:19] == 1 && w[2:0] < 6) rng[c] = w[2:0];
            end
        end
        @(negedge core_clk);
        for (int c = 0; c < 4; c++) begin
            e[c*12 +: 12] = codes[c];
            l[c*12 +: 12] = rng[c] > 2 && twos_comp_sel ? codes[c] ^ 'h800 : codes[c];
        end
        check({code_d, code_c, code_b, code_a}, e);
        check({level_d, level_c, level_b, level_a}, l);
        check(range_a_to_d, {rng[3][2:0], rng[2][2:0], rng[1][2:0], rng[0][2:0]});
    endtask
    initial begin
        void'($urandom(93));
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge core_clk);
            twos_comp_sel <= i >= 25;
            w = $urandom;
            // Late frames also reach unused select codes 6 and 7 and unused channel codes 5 to 7
            w[21:19] = i % 4 + (i / 2 == 23 ? 4 : 0);
            w[18:16] = i < 40 ? i % 5 : (i + 1) % 8;
            w[23] = i % 7 == 3;
            // Odd-length frames at the end must leave all state untouched
            frame(i < 48 ? 24 : 23 + (i - 48) * 2);
        end
        wrap_up;
    end
endmodule

/* File: bench/serial_host_model.sv */
/* Host serial port model: frames MSB first under frame select.
   Assumes the caller leaves a gap between frames. */
`timescale 1ns/1ps
module serial_host_model (
    output logic serial_clk,
    output logic frame_sel_n,
    output logic serial_data_in
);
    initial begin
        serial_clk = 1'b0;
        frame_sel_n = 1'b1;
        serial_data_in = 1'b1;
    end
    // Clock idles low outside frames; 48 ns period, off the core clock phase
    task automatic send(input logic [23:0] word, input int nbits);
        logic [23:0] w;
        w = word & 24'hbfffff;
        #13.1 frame_sel_n = 1'b0;
        for (int k = 0; k < nbits; k++) begin
            serial_data_in = k < 24 ? w[23 - k] : 1'b0;
            #24 serial_clk = 1'b1;
            #24 serial_clk = 1'b0;
        end
        #24 frame_sel_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask
endmodule

/* File: src/frame_decoder_map.vh */
/*
 * Constants for the serial frame decoder: frame layout, target and
 * channel codes, range codes and interface reset values.
 * Assumes it is included by bare name from the decoder module only.
 */
`ifndef FRAME_DECODER_MAP_VH
`define FRAME_DECODER_MAP_VH

`define FRAME_BITS 24
`define FRAME_CNT_W 5
`define FLD_RW 23
`define FLD_ZERO 22
`define FLD_SEL_HI 21
`define FLD_SEL_LO 19
`define FLD_CH_HI 18
`define FLD_CH_LO 16
`define FLD_DATA_HI 15
`define FLD_CODE_LO 4
`define FLD_RANGE_HI 2

`define SEL_DAC 3'h0
`define SEL_RANGE 3'h1
`define SEL_POWER 3'h2
`define SEL_CTRL 3'h3

`define CH_ALL 3'h4

`define RANGE_MAX 3'h5
`define RANGE_BIPOLAR_MIN 3'h3

`define MIDSCALE_CODE 12'h800
`define CODE_RESET 12'h000
`define RANGE_RESET 3'h0
`define DATA_RESET 16'h0000

`endif

/* File: src/quad_dac_serial_frame_decoder.v */
/*
 * Serial command frame decoder for a quad 12-bit DAC. Shifts 24-bit
 * frames in MSB first, checks length, splits fields and routes writes
 * and read requests to channel data, range, power and control targets.
 * Assumes serial clock, frame select and data come from a host in
 * another clock domain, much slower than core_clk.
 */
// What this block does
// - A frame is exactly 24 bits long.
// - Bits arrive MSB first and shift toward the register top.
// - Bit 23 read/write, 22 reserved, 21-19 select, 18-16 channel, 15-0 data.
// - Select 0 data, 1 range, 2 power, 3 control register.
// - Read/write flag picks a write or a read request.
// - Every target register can be written and read.
// - Offset binary: 0x800 zero, all ones top, all zeros bottom.
// - Twos complement: zero is zero, 0x7ff top, 0x800 bottom.
// - Straight binary rises from zero, one 4096th of span per step.
// - Channel code comes from data bits 15 to 4.
// - Range from three low data bits; 0-2 unipolar, 3-5 bipolar.
`timescale 1ns/1ps
`include "frame_decoder_map.vh"

module quad_dac_serial_frame_decoder #(
    parameter CODE_W = 12
) (
    input wire core_clk,
    input wire reset_n,
    input wire serial_clk,
    input wire frame_sel_n,
    input wire serial_data_in,
    input wire twos_comp_sel,
    output reg frame_valid,
    output reg frame_error,
    output reg frame_read,
    output reg [2:0] target_sel,
    output reg [2:0] channel_addr,
    output reg [15:0] frame_data,
    output reg [3:0] channel_we,
    output reg [3:0] channel_re,
    output reg range_we,
    output reg power_we,
    output reg ctrl_we,
    output reg reg_re,
    output reg [CODE_W-1:0] code_a,
    output reg [CODE_W-1:0] code_b,
    output reg [CODE_W-1:0] code_c,
    output reg [CODE_W-1:0] code_d,
    output reg [11:0] level_a,
    output reg [11:0] level_b,
    output reg [11:0] level_c,
    output reg [11:0] level_d,
    output reg [11:0] range_a_to_d
);

// Bipolar codes become an unsigned level: 0 = most negative, 0x800 = zero
function [11:0] to_level;
    input [11:0] code;
    input bipolar;
    input twos;
    begin
        if (bipolar && twos)
            to_level = code ^ `MIDSCALE_CODE;
        else
            to_level = code;
    end
endfunction

function [3:0] ch_mask;
    input [2:0] ch;
    begin
        case (ch)
            3'h0: ch_mask = 4'h1;
            3'h1: ch_mask = 4'h2;
            3'h2: ch_mask = 4'h4;
            3'h3: ch_mask = 4'h8;
            `CH_ALL: ch_mask = 4'hf;
            default: ch_mask = 4'h0;
        endcase
    end
endfunction

// Two-flop synchronisers; the first stage feeds only the second
reg [2:0] sck_s;
reg [1:0] fs_s;
reg [1:0] sd_s;
reg twos_q1;
reg twos_q2;
wire sck_rise = sck_s[1] & ~sck_s[2];
wire fs_active = ~fs_s[1];

reg [`FRAME_BITS-1:0] shift;
reg [`FRAME_CNT_W-1:0] count;
reg overrun;
reg fs_prev;

reg [2:0] range_ch [0:3];
reg [CODE_W-1:0] code_r [0:3];

wire frame_end = fs_prev & ~fs_active;
wire frame_ok = (count == `FRAME_BITS) && !overrun;
wire [2:0] sel = shift[`FLD_SEL_HI:`FLD_SEL_LO];
wire [2:0] ch = shift[`FLD_CH_HI:`FLD_CH_LO];
wire [3:0] mask = ch_mask(ch);
wire is_write = ~shift[`FLD_RW];
wire [2:0] rng = shift[`FLD_RANGE_HI:0];

always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        sck_s <= 3'h0;
        fs_s <= 2'h3;
        sd_s <= 2'h0;
        twos_q1 <= 1'b0;
        twos_q2 <= 1'b0;
        fs_prev <= 1'b0;
    end else begin
        sck_s <= {sck_s[1:0], serial_clk};
        fs_s <= {fs_s[0], frame_sel_n};
        sd_s <= {sd_s[0], serial_data_in};
        twos_q1 <= twos_comp_sel;
        twos_q2 <= twos_q1;
        fs_prev <= fs_active;
    end
end

// Data is sampled in the same core cycle as the synchronised clock edge,
// which is safe because both pass the same two-flop delay.
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        shift <= {`FRAME_BITS{1'b0}};
        count <= {`FRAME_CNT_W{1'b0}};
        overrun <= 1'b0;
    end else if (fs_active && !fs_prev) begin
        count <= {`FRAME_CNT_W{1'b0}};
        overrun <= 1'b0;
    end else if (fs_active && sck_rise) begin
        shift <= {shift[`FRAME_BITS-2:0], sd_s[1]};
        if (count == `FRAME_BITS)
            overrun <= 1'b1;
        else
            count <= count + 1'b1;
    end
end

integer i;
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        frame_valid <= 1'b0;
        frame_error <= 1'b0;
        frame_read <= 1'b0;
        target_sel <= 3'h0;
        channel_addr <= 3'h0;
        frame_data <= `DATA_RESET;
        channel_we <= 4'h0;
        channel_re <= 4'h0;
        range_we <= 1'b0;
        power_we <= 1'b0;
        ctrl_we <= 1'b0;
        reg_re <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            range_ch[i] <= `RANGE_RESET;
            code_r[i] <= {CODE_W{1'b0}};
        end
    end else begin
        frame_valid <= frame_end & frame_ok;
        frame_error <= frame_end & ~frame_ok;
        channel_we <= 4'h0;
        channel_re <= 4'h0;
        range_we <= 1'b0;
        power_we <= 1'b0;
        ctrl_we <= 1'b0;
        reg_re <= 1'b0;
        if (frame_end && frame_ok) begin
            frame_read <= shift[`FLD_RW];
            target_sel <= sel;
            channel_addr <= ch;
            frame_data <= shift[`FLD_DATA_HI:0];
            reg_re <= ~is_write;
            case (sel)
                `SEL_DAC: begin
                    if (is_write)
                        channel_we <= mask;
                    else
                        channel_re <= mask;
                    for (i = 0; i < 4; i = i + 1)
                        if (is_write && mask[i])
                            code_r[i] <= shift[`FLD_DATA_HI:`FLD_DATA_HI-CODE_W+1];
                end
                `SEL_RANGE: begin
                    range_we <= is_write;
                    for (i = 0; i < 4; i = i + 1)
                        if (is_write && mask[i] && rng <= `RANGE_MAX)
                            range_ch[i] <= rng;
                end
                `SEL_POWER: power_we <= is_write;
                `SEL_CTRL: ctrl_we <= is_write;
                default: ;
            endcase
        end
    end
end

// Output levels follow code, range and coding selection
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        code_a <= {CODE_W{1'b0}};
        code_b <= {CODE_W{1'b0}};
        code_c <= {CODE_W{1'b0}};
        code_d <= {CODE_W{1'b0}};
        level_a <= `CODE_RESET;
        level_b <= `CODE_RESET;
        level_c <= `CODE_RESET;
        level_d <= `CODE_RESET;
        range_a_to_d <= 12'h000;
    end else begin
        code_a <= code_r[0];
        code_b <= code_r[1];
        code_c <= code_r[2];
        code_d <= code_r[3];
        level_a <= to_level(code_r[0], range_ch[0] >= `RANGE_BIPOLAR_MIN, twos_q2);
        level_b <= to_level(code_r[1], range_ch[1] >= `RANGE_BIPOLAR_MIN, twos_q2);
        level_c <= to_level(code_r[2], range_ch[2] >= `RANGE_BIPOLAR_MIN, twos_q2);
        level_d <= to_level(code_r[3], range_ch[3] >= `RANGE_BIPOLAR_MIN, twos_q2);
        range_a_to_d <= {range_ch[3], range_ch[2], range_ch[1], range_ch[0]};
    end
end

endmodule
